// ### core/r5s_rail_enable.sv
// Summary of operation
// - mask bit 7 drops aux LDO three good
// - mask bit 6 drops aux LDO two good
// - mask bit 5 drops switch A one good
// - mask bit 4 drops rail six good
// - mask bit 3 drops rail four good
// - mask bit 2 drops rail three good
// - mask bit 1 drops rail two good
// - mask bit 0 drops rail one good
// - second mask bit 1 drops B-two/aux-one good
// - second mask bit 0 drops switch B one
// - source select field picks control pin
// - code 111 forces source high
// - rise delay code sets rising edge delay
// - fall delay code sets falling delay
// - delays may vary ten percent
`timescale 1ns/1ps
module r5s_rail_enable #(
    parameter int CYC_PER_MS    = r5s_pkg::CYC_PER_MS,
    parameter int RSVD_DELAY_MS = 0
) (
    // clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic                        ce,
    // axi4-lite
    input  wire logic [r5s_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [r5s_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // pins
    input  wire logic [5:0]                  control_pin,
    input  wire logic [9:0]                  power_good,
    output logic                             rail_enable
);
    import r5s_pkg::*;

    // ======================================================
    // state
    typedef struct packed {
        logic [5:0] pin_m;
        logic [5:0] pin_s;
        logic [9:0] pg_m;
        logic [9:0] pg_s;
        logic [7:0] mask_a;
        logic [7:0] sel_b;
        logic [7:0] delays;
        logic       cond;
    } r5s_top_t;

    r5s_top_t          s_q;
    r5s_top_t          s_d;
    logic              wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [7:0]        wr_byte;
    logic [31:0]       rd_data;
    logic              src_level;
    logic              pg_ok;
    logic              dly_busy;

    // ======================================================
    // source multiplexer
    // pair code needs both pins high; code 111 needs no pin at all
    function automatic logic src_pick(input logic [2:0] sel, input logic [5:0] pin);
        unique case (r5s_src_t'(sel))
            SRC_PIN1:  src_pick = pin[0];
            SRC_PIN2:  src_pick = pin[1];
            SRC_PIN5:  src_pick = pin[4];
            SRC_PIN4:  src_pick = pin[3];
            SRC_PIN3:  src_pick = pin[2];
            SRC_PIN34: src_pick = pin[2] & pin[3];
            SRC_PIN6:  src_pick = pin[5];
            SRC_ONE:   src_pick = 1'b1;
        endcase
    endfunction

    always_comb begin
        src_level = src_pick(s_q.sel_b[SEL_LSB +: 3], s_q.pin_s);
        pg_ok = (s_q.pg_s[MSK_LDO3]  | s_q.mask_a[MSK_LDO3])
              & (s_q.pg_s[MSK_LDO2]  | s_q.mask_a[MSK_LDO2])
              & (s_q.pg_s[MSK_SW_A1] | s_q.mask_a[MSK_SW_A1])
              & (s_q.pg_s[MSK_RAIL6] | s_q.mask_a[MSK_RAIL6])
              & (s_q.pg_s[MSK_RAIL4] | s_q.mask_a[MSK_RAIL4])
              & (s_q.pg_s[MSK_RAIL3] | s_q.mask_a[MSK_RAIL3])
              & (s_q.pg_s[MSK_RAIL2] | s_q.mask_a[MSK_RAIL2])
              & (s_q.pg_s[MSK_RAIL1] | s_q.mask_a[MSK_RAIL1])
              & (s_q.pg_s[PG_B_LSB + MSK_SW_B2A1] | s_q.sel_b[MSK_SW_B2A1])
              & (s_q.pg_s[PG_B_LSB + MSK_SW_B1] | s_q.sel_b[MSK_SW_B1]);
    end

    // ======================================================
    // register read
    always_comb begin
        rd_data = 32'h00000000;
        case (s_axi_araddr[7:2])
            IDX_MASK_A: rd_data[7:0] = s_q.mask_a;
            IDX_SEL_B:  rd_data[7:0] = s_q.sel_b;
            IDX_DELAYS: rd_data[7:0] = s_q.delays;
            IDX_STATUS: begin
                rd_data[ST_ENABLE] = rail_enable;
                rd_data[ST_COND]   = s_q.cond;
                rd_data[ST_BUSY]   = dly_busy;
            end
            default:    rd_data = 32'h00000000;
        endcase
        if (s_axi_araddr[1:0] != 2'h0) begin
            rd_data = 32'h00000000;
        end
    end

    // ======================================================
    // next state
    always_comb begin
        s_d = s_q;
        // pins and goods come from other domains: two flops before use
        s_d.pin_m = control_pin;
        s_d.pin_s = s_q.pin_m;
        s_d.pg_m  = power_good;
        s_d.pg_s  = s_q.pg_m;
        s_d.cond  = src_level & pg_ok;
        if (wr_fire && wr_addr[1:0] == 2'h0) begin
            case (wr_addr[7:2])
                IDX_MASK_A: s_d.mask_a = wr_byte;
                IDX_SEL_B:  s_d.sel_b  = wr_byte;
                IDX_DELAYS: s_d.delays = wr_byte;
                default:    s_d.mask_a = s_q.mask_a;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q        <= '0;
            s_q.mask_a <= RST_MASK_A;
            s_q.sel_b  <= RST_SEL_B;
            s_q.delays <= RST_DELAYS;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ======================================================
    // bus slave and edge timer
    r5s_axil_slave u_bus (
        .aclk          (aclk),
        .aresetn       (aresetn),
        .ce            (ce),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_fire       (wr_fire),
        .wr_addr       (wr_addr),
        .wr_byte       (wr_byte),
        .rd_data       (rd_data)
    );

    // delays are exact counts, well inside the allowed spread
    r5s_edge_delay #(
        .CYC_PER_MS    (CYC_PER_MS),
        .RSVD_DELAY_MS (RSVD_DELAY_MS)
    ) u_dly (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .level_in  (s_q.cond),
        .rise_code (s_q.delays[RISE_LSB +: 3]),
        .fall_code (s_q.delays[FALL_LSB +: 3]),
        .level_out (rail_enable),
        .busy      (dly_busy)
    );

    // ======================================================
    // assertions
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_ldo3_mask;
        (ce && !s_q.pg_s[MSK_LDO3] && !s_q.mask_a[MSK_LDO3]) |=> !s_q.cond;
    endproperty
    a_ldo3_mask: assert property (p_ldo3_mask) else $error("ldo3 good ignored");

    property p_ldo2_mask;
        (ce && !s_q.pg_s[MSK_LDO2] && !s_q.mask_a[MSK_LDO2]) |=> !s_q.cond;
    endproperty
    a_ldo2_mask: assert property (p_ldo2_mask) else $error("ldo2 good ignored");

    property p_sw_a1_mask;
        (ce && !s_q.pg_s[MSK_SW_A1] && !s_q.mask_a[MSK_SW_A1]) |=> !s_q.cond;
    endproperty
    a_sw_a1_mask: assert property (p_sw_a1_mask) else $error("a1 good ignored");

    property p_rail6_mask;
        (ce && !s_q.pg_s[MSK_RAIL6] && !s_q.mask_a[MSK_RAIL6]) |=> !s_q.cond;
    endproperty
    a_rail6_mask: assert property (p_rail6_mask) else $error("rail6 good ignored");

    property p_rail4_mask;
        (ce && !s_q.pg_s[MSK_RAIL4] && !s_q.mask_a[MSK_RAIL4]) |=> !s_q.cond;
    endproperty
    a_rail4_mask: assert property (p_rail4_mask) else $error("rail4 good ignored");

    property p_rail3_mask;
        (ce && !s_q.pg_s[MSK_RAIL3] && !s_q.mask_a[MSK_RAIL3]) |=> !s_q.cond;
    endproperty
    a_rail3_mask: assert property (p_rail3_mask) else $error("rail3 good ignored");

    property p_rail2_mask;
        (ce && !s_q.pg_s[MSK_RAIL2] && !s_q.mask_a[MSK_RAIL2]) |=> !s_q.cond;
    endproperty
    a_rail2_mask: assert property (p_rail2_mask) else $error("rail2 good ignored");

    property p_rail1_mask;
        (ce && !s_q.pg_s[MSK_RAIL1] && !s_q.mask_a[MSK_RAIL1]) |=> !s_q.cond;
    endproperty
    a_rail1_mask: assert property (p_rail1_mask) else $error("rail1 good ignored");

    property p_b2_mask;
        (ce && !s_q.pg_s[PG_B_LSB + MSK_SW_B2A1] && !s_q.sel_b[MSK_SW_B2A1]) |=> !s_q.cond;
    endproperty
    a_b2_mask: assert property (p_b2_mask) else $error("b2 good ignored");

    property p_b1_mask;
        (ce && !s_q.pg_s[PG_B_LSB + MSK_SW_B1] && !s_q.sel_b[MSK_SW_B1]) |=> !s_q.cond;
    endproperty
    a_b1_mask: assert property (p_b1_mask) else $error("b1 good ignored");

    property p_pin34;
        (ce && s_q.sel_b[SEL_LSB +: 3] == 3'h5 && !(s_q.pin_s[2] && s_q.pin_s[3]))
            |=> !s_q.cond;
    endproperty
    a_pin34: assert property (p_pin34) else $error("pin pair not both high");

    property p_force_one;
        (ce && s_q.sel_b[SEL_LSB +: 3] == 3'h7 && pg_ok) |=> s_q.cond;
    endproperty
    a_force_one: assert property (p_force_one) else $error("forced source not high");

    property p_rise_now;
        (ce && s_q.cond && !rail_enable && s_q.delays[2:0] == 3'h0) |=> rail_enable;
    endproperty
    a_rise_now: assert property (p_rise_now) else $error("zero rise delay late");

    property p_fall_now;
        (ce && !s_q.cond && rail_enable && s_q.delays[5:3] == 3'h0) |=> !rail_enable;
    endproperty
    a_fall_now: assert property (p_fall_now) else $error("zero fall delay late");

    property p_rise_cause;
        $rose(rail_enable) |-> $past(s_q.cond);
    endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("enable without cause");

    property p_fall_cause;
        $fell(rail_enable) |-> !$past(s_q.cond);
    endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("drop without cause");

    property p_pin1;
        (ce && s_q.sel_b[SEL_LSB +: 3] == 3'h0 && !s_q.pin_s[0]) |=> !s_q.cond;
    endproperty
    a_pin1: assert property (p_pin1) else $error("pin one low but condition high");

    // ======================================================
    // coverage

    c_rise: cover property ($rose(rail_enable));
    c_fall: cover property ($fell(rail_enable));
    c_forced: cover property (s_q.sel_b[SEL_LSB +: 3] == 3'h7 && s_q.cond);
    c_pair: cover property (s_q.sel_b[SEL_LSB +: 3] == 3'h5 && s_q.cond);
    c_rsvd_code: cover property (s_q.delays[RISE_LSB +: 3] == 3'h6 && dly_busy);

endmodule

// ### core/r5s_pkg.sv
package r5s_pkg;

    // ======================================================
    // register map: printed offsets are indices, byte address = 4 * index
    localparam int         ADDR_W       = 8;
    localparam logic [5:0] IDX_MASK_A   = 6'h13;
    localparam logic [5:0] IDX_SEL_B    = 6'h14;
    localparam logic [5:0] IDX_DELAYS   = 6'h15;
    localparam logic [5:0] IDX_STATUS   = 6'h1f;
    localparam logic [7:0] RST_MASK_A   = 8'h00;
    localparam logic [7:0] RST_SEL_B    = 8'h00;
    localparam logic [7:0] RST_DELAYS   = 8'h00;

    // ======================================================
    // field positions
    localparam int MSK_LDO3     = 7;
    localparam int MSK_LDO2     = 6;
    localparam int MSK_SW_A1    = 5;
    localparam int MSK_RAIL6    = 4;
    localparam int MSK_RAIL4    = 3;
    localparam int MSK_RAIL3    = 2;
    localparam int MSK_RAIL2    = 1;
    localparam int MSK_RAIL1    = 0;
    localparam int MSK_SW_B2A1  = 1;
    localparam int MSK_SW_B1    = 0;
    localparam int SEL_LSB      = 2;
    localparam int RISE_LSB     = 0;
    localparam int FALL_LSB     = 3;
    // power_good vector: [7:0] line up with mask_a, [9:8] with sel_b[1:0]
    localparam int PG_B_LSB     = 8;
    localparam int ST_ENABLE    = 0;
    localparam int ST_COND      = 1;
    localparam int ST_BUSY      = 2;

    // ======================================================
    // enable sources
    typedef enum logic [2:0] {
        SRC_PIN1  = 3'h0,
        SRC_PIN2  = 3'h1,
        SRC_PIN5  = 3'h2,
        SRC_PIN4  = 3'h3,
        SRC_PIN3  = 3'h4,
        SRC_PIN34 = 3'h5,
        SRC_PIN6  = 3'h6,
        SRC_ONE   = 3'h7
    } r5s_src_t;

    // ======================================================
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int NS_PER_MS     = 1000000;
    localparam int CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
    localparam logic [6:0] DLY_MS_1 = 7'h02;
    localparam logic [6:0] DLY_MS_2 = 7'h04;
    localparam logic [6:0] DLY_MS_3 = 7'h08;
    localparam logic [6:0] DLY_MS_4 = 7'h10;
    localparam logic [6:0] DLY_MS_5 = 7'h18;
    localparam logic [6:0] DLY_MS_7 = 7'h40;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [6:0] delay_ms(input logic [2:0] code,
                                            input logic [6:0] rsvd_ms);
        case (code)
            3'h0:    delay_ms = 7'h00;
            3'h1:    delay_ms = DLY_MS_1;
            3'h2:    delay_ms = DLY_MS_2;
            3'h3:    delay_ms = DLY_MS_3;
            3'h4:    delay_ms = DLY_MS_4;
            3'h5:    delay_ms = DLY_MS_5;
            3'h6:    delay_ms = rsvd_ms;
            default: delay_ms = DLY_MS_7;
        endcase
    endfunction

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        reg_hit = (addr[1:0] == 2'h0) && (idx == IDX_MASK_A || idx == IDX_SEL_B ||
                  idx == IDX_DELAYS || idx == IDX_STATUS);
    endfunction

endpackage

// ### core/r5s_axil_slave.sv
`timescale 1ns/1ps
module r5s_axil_slave (
    // clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic                        ce,
    // axi4-lite
    input  wire logic [r5s_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [r5s_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // register side
    output logic                             wr_fire,
    output logic [r5s_pkg::ADDR_W-1:0]       wr_addr,
    output logic [7:0]                       wr_byte,
    input  wire logic [31:0]                 rd_data
);
    import r5s_pkg::*;

    typedef struct packed {
        logic              aw_have;
        logic              w_have;
        logic [ADDR_W-1:0] awaddr;
        logic [7:0]        wbyte;
        logic              wlane;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } r5s_bus_t;

    r5s_bus_t s_q;
    r5s_bus_t s_d;
    logic     fire;

    // write lands in the same edge that raises bvalid, so a read after bvalid sees it
    assign fire    = ce && s_q.aw_have && s_q.w_have && !s_q.bvalid;
    // lane 0 off still answers, but leaves the register alone
    assign wr_fire = fire && s_q.wlane;
    assign wr_addr = s_q.awaddr;
    assign wr_byte = s_q.wbyte;

    always_comb begin
        s_d = s_q;
        if (s_axi_awvalid && s_q.awready) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_q.wready) begin
            s_d.w_have = 1'b1;
            s_d.wbyte  = s_axi_wdata[7:0];
            s_d.wlane  = s_axi_wstrb[0];
        end
        if (fire) begin
            s_d.bvalid  = 1'b1;
            s_d.bresp   = reg_hit(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready  = !s_d.w_have && !s_d.bvalid;
        if (s_axi_arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_data;
            s_d.rresp  = reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end
        if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        s_d.arready = !s_d.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready = s_q.awready;
    assign s_axi_wready  = s_q.wready;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = s_q.arready;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

endmodule

// ### core/r5s_edge_delay.sv
`timescale 1ns/1ps
module r5s_edge_delay #(
    parameter int CYC_PER_MS    = r5s_pkg::CYC_PER_MS,
    parameter int RSVD_DELAY_MS = 0
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // level and timing codes
    input  wire logic        level_in,
    input  wire logic [2:0]  rise_code,
    input  wire logic [2:0]  fall_code,
    output logic             level_out,
    output logic             busy
);
    import r5s_pkg::*;

    if (CYC_PER_MS < 1 || CYC_PER_MS > 1048575) begin : g_bad_rate
        $error("r5s_edge_delay: CYC_PER_MS out of range");
    end
    if (RSVD_DELAY_MS < 0 || RSVD_DELAY_MS > 127) begin : g_bad_rsvd
        $error("r5s_edge_delay: RSVD_DELAY_MS out of range");
    end

    typedef struct packed {
        logic        out;
        logic [19:0] pre;
        logic [6:0]  ms;
    } r5s_dly_t;

    r5s_dly_t   s_q;
    r5s_dly_t   s_d;
    logic [6:0] target;

    always_comb begin
        s_d = s_q;
        // target follows the direction being waited for
        target = level_in ? delay_ms(rise_code, 7'(RSVD_DELAY_MS))
                          : delay_ms(fall_code, 7'(RSVD_DELAY_MS));
        if (level_in == s_q.out) begin
            // a glitch shorter than the delay restarts the wait
            s_d.pre = 20'h00000;
            s_d.ms  = 7'h00;
        end else if (target == 7'h00) begin
            s_d.out = level_in;
        end else if (s_q.pre == 20'(CYC_PER_MS - 1)) begin
            s_d.pre = 20'h00000;
            if (s_q.ms + 7'h01 >= target) begin
                s_d.out = level_in;
                s_d.ms  = 7'h00;
            end else begin
                s_d.ms = s_q.ms + 7'h01;
            end
        end else begin
            s_d.pre = s_q.pre + 20'h00001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign level_out = s_q.out;
    assign busy      = level_in != s_q.out;

endmodule

// ### verification/r5s_pin_host.sv
`timescale 1ns/1ps
// ======================================================
// host driving the control pins; LAT models a slow host
module r5s_pin_host #(
    parameter int LAT = 3
) (
    // clock
    input  wire logic        aclk,
    // commanded and driven pin levels
    input  wire logic [5:0]  pin_cmd,
    output logic [5:0]       control_pin
);
    logic [5:0] pipe_q [LAT];

    // host drives the pins push-pull, so no released level exists
    always_ff @(posedge aclk) begin
        pipe_q[0] <= pin_cmd;
        for (int i = 1; i < LAT; i++) begin
            pipe_q[i] <= pipe_q[i-1];
        end
    end

    assign control_pin = pipe_q[LAT-1];
endmodule

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
    import r5s_pkg::*;
    // ======================================================
    // clock, bus and pins
    localparam int CYC = 10;
    localparam int RSVD_MS = 3;
    localparam logic [7:0] A_MSK = {IDX_MASK_A, 2'h0};
    localparam logic [7:0] A_SEL = {IDX_SEL_B, 2'h0};
    localparam logic [7:0] A_DLY = {IDX_DELAYS, 2'h0};
    localparam logic [7:0] A_ST  = {IDX_STATUS, 2'h0};
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, rail_enable;
    logic [1:0]  bresp, rresp;
    logic [5:0]  pin_cmd = 6'h00, control_pin;
    logic [9:0]  power_good = 10'h000;
    int          n_errors = 0;
    int          n_tests = 0;
    int          ms_tab [8] = '{0, 2, 4, 8, 16, 24, RSVD_MS, 64};
    logic [5:0]  pat [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0c, 6'h20, 6'h00};

    always #4 aclk = ~aclk;

    r5s_pin_host #(.LAT(3)) r5s_pin_host_inst (
        .aclk(aclk), .pin_cmd(pin_cmd), .control_pin(control_pin));

    r5s_rail_enable #(.CYC_PER_MS(CYC), .RSVD_DELAY_MS(RSVD_MS)) r5s_rail_enable_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .control_pin(control_pin), .power_good(power_good), .rail_enable(rail_enable));

    // ======================================================
    // checks and bus tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h got %h", nm, e, g);
            n_errors++;
        end
    endtask

    // waits have no limit of their own: only the watchdog ends a hang
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        // idle edge: a next call must not drop and raise bready together
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", {24'h0, e}, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
        @(posedge aclk);
    endtask

    task automatic cfg(input logic [9:0] m, input logic [2:0] s);
        axi_wr(A_MSK, m[7:0], RESP_OKAY);
        axi_wr(A_SEL, {3'h0, s, m[9:8]}, RESP_OKAY);
    endtask

    // pins pass host latency, two sync stages and the condition flop
    task automatic en_is(input logic e);
        repeat (12) @(posedge aclk);
        chk("rail_enable", {31'h0, e}, {31'h0, rail_enable});
    endtask

    // tolerance band plus a few cycles of input pipeline
    task automatic meas(input string nm, input logic lvl, input int ms);
        int n;
        int d;
        n = 0;
        d = ms * CYC;
        while (rail_enable !== lvl && n < 1000) begin
            @(posedge aclk);
            n++;
        end
        n_tests++;
        if (n < d * 9 / 10 || n > d * 11 / 10 + 8) begin
            $display("[FAIL] %s expected %0d got %0d", nm, d, n);
            n_errors++;
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ======================================================
    // watchdog: all tests need well under 10000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        summarize();
    end

    // ======================================================
    // tests
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(A_MSK, RST_MASK_A, RESP_OKAY);
        axi_rd(A_SEL, RST_SEL_B, RESP_OKAY);
        axi_rd(A_DLY, RST_DELAYS, RESP_OKAY);
        axi_wr(A_MSK, 8'ha5, RESP_OKAY);
        axi_rd(A_MSK, 8'ha5, RESP_OKAY);
        axi_wr(A_DLY, 8'h3f, RESP_OKAY);
        axi_rd(A_DLY, 8'h3f, RESP_OKAY);
        axi_wr(8'h40, 8'hff, RESP_SLVERR);
        axi_rd(8'h40, 8'h00, RESP_SLVERR);
        axi_rd(8'h4d, 8'h00, RESP_SLVERR);
        axi_wr(A_DLY, 8'h00, RESP_OKAY);
        $display("test registers done");

        for (int i = 0; i < 10; i++) begin
            cfg(10'h000, 3'h7);
            power_good <= 10'h3ff ^ (10'h001 << i);
            en_is(1'b0);
            cfg(10'h001 << i, 3'h7);
            en_is(1'b1);
        end
        $display("test masks done");

        power_good <= 10'h3ff;
        for (int c = 0; c < 8; c++) begin
            cfg(10'h000, c[2:0]);
            pin_cmd <= pat[c];
            en_is(1'b1);
            pin_cmd <= ~pat[c];
            en_is(c == 7);
        end
        cfg(10'h000, 3'h5);
        pin_cmd <= 6'h04;
        en_is(1'b0);
        pin_cmd <= 6'h08;
        en_is(1'b0);
        $display("test sources done");

        // rise and fall codes differ so a swapped field shows
        cfg(10'h000, 3'h7);
        en_is(1'b1);
        axi_rd(A_ST, 8'h03, RESP_OKAY);
        for (int k = 0; k < 8; k++) begin
            axi_wr(A_DLY, {2'h0, ~k[2:0], k[2:0]}, RESP_OKAY);
            power_good <= 10'h3fe;
            meas("fall delay", 1'b0, ms_tab[7-k]);
            power_good <= 10'h3ff;
            meas("rise delay", 1'b1, ms_tab[k]);
        end
        // long fall wait: status shows enable still high, condition low, timer running
        axi_wr(A_DLY, 8'h38, RESP_OKAY);
        axi_wr(A_ST, 8'h00, RESP_OKAY);
        power_good <= 10'h3fe;
        en_is(1'b1);
        axi_rd(A_ST, 8'h05, RESP_OKAY);
        $display("test delays done");
        summarize();
    end
endmodule
